// >>> verilog/rcfg_pkg.sv
// Behaviour
// - Mute off when mute pin and bit differ
// - Auto-poll bit alternates sleep and polling
// - Sleep code doubles period, 10ms to 1280ms
// - Window code resets to 111, the shortest
// - 433.92MHz window 570..305us, scaled by bandwidth
// - 315MHz window 785..420us, halved per bandwidth step
// - Valid-bit count codes select 0,4,8,16
// - Slice code 01,10,11,00 gives 30..60 percent
// - Bandwidth code 00..11 gives 1625..13000Hz
// - Idle port drives demodulated data out when awake
// - Clock high releases data pin to host
// - No clock edge for 200us (one 5kHz period) resets interface
// - Bits shift in most significant first
// - Partial load ends at bit 0
// - Stop: data pulse with clock high, clock low
// - Polling holds the data output low
// - Valid bit outlasts window, shorter is bad
// - Four consecutive bad bits return to sleep
// - After release stays awake until reprogrammed
package rcfg_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned SCLK_MIN_HZ = 5_000;
  localparam int unsigned SCLK_TO_CYC = CLK_HZ / SCLK_MIN_HZ;
  localparam int unsigned SLEEP_BASE_MS = 10;
  localparam int unsigned SLEEP_BASE_CYC = CLK_HZ / 1000 * SLEEP_BASE_MS;
  localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;
  localparam logic [2:0] BAD_LIMIT = 3'h4;

  // ----------------------------------------------------------------
  // Setting word
  // ----------------------------------------------------------------
  localparam int unsigned WORD_W = 20;
  localparam logic [4:0] WORD_W5 = 5'h14;
  localparam logic [19:0] WORD_RST = 20'h42e78;

  typedef struct packed {
    logic must_zero_hi;     // Bit 19
    logic must_one;         // Bit 18
    logic mute_control_bit; // Bit 17
    logic must_zero_lo;     // Bit 16
    logic autopoll_enable_bit; // Bit 15
    logic [2:0] sleep_time;    // Bits 14:12
    logic [2:0] check_window;  // Bits 11:9
    logic [1:0] valid_count;   // Bits 8:7
    logic [1:0] slice_level;   // Bits 6:5
    logic [1:0] demod_bw;      // Bits 4:3
    logic [2:0] low_bits;      // Bits 2:0
  } rcfg_word_t;

  // Valid-bit requirements per code
  localparam logic [4:0] VBITS_C0 = 5'h00;
  localparam logic [4:0] VBITS_C1 = 5'h04;
  localparam logic [4:0] VBITS_C2 = 5'h08;
  localparam logic [4:0] VBITS_C3 = 5'h10;

  // Window in us at narrowest bandwidth code 00, code 7 first
  localparam logic [7:0][9:0] WIN_433_US = {10'd305, 10'd343, 10'd381,
    10'd419, 10'd457, 10'd494, 10'd532, 10'd570};
  localparam logic [7:0][9:0] WIN_315_US = {10'd420, 10'd473, 10'd525,
    10'd577, 10'd629, 10'd681, 10'd733, 10'd785};

  // Pin sampler bit positions
  localparam int unsigned PIN_SCLK = 0;
  localparam int unsigned PIN_DIO = 1;
  localparam int unsigned PIN_DEMOD = 2;
  localparam int unsigned PIN_MUTE = 3;
  localparam int unsigned PIN_BAND = 4;
  localparam int unsigned PIN_N = 5;

  typedef enum {
    SP_IDLE, SP_REL, SP_ARM_LO, SP_ARM_HI, SP_ARM_PULSE,
    SP_SHIFT, SP_STOP1, SP_STOP2, SP_HOLD
  } rcfg_sp_t;

  typedef enum { RX_AWAKE, RX_SLEEP, RX_POLL } rcfg_rx_t;

endpackage

// >>> verilog/rcfg_sync.sv
`timescale 1ns/1ps
module rcfg_sync #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Levels
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_r;

  // ------------------------------------------------------------
  // Two-flop level synchroniser
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      meta_r <= '0;
      sync_out <= '0;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule

// >>> verilog/rcfg_port.sv
`timescale 1ns/1ps
module rcfg_port #(
  parameter int unsigned TIMEOUT_CYC = rcfg_pkg::SCLK_TO_CYC,
  parameter int unsigned SLEEP_BASE_CYC = rcfg_pkg::SLEEP_BASE_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Serial pins
  input wire logic sclk_pin,
  input wire logic dio_in,
  output logic dio_out,
  output logic dio_oe,
  // Parallel pins
  input wire logic noise_mute_pin,
  input wire logic band_pick_0,
  // Receive path
  input wire logic demod_raw,
  output logic radio_sleep,
  output logic mute_enable,
  // Setting word
  output rcfg_pkg::rcfg_word_t cfg_word
);

  // ------------------------------------------------------------
  // Pin sampling
  // ------------------------------------------------------------
  logic [rcfg_pkg::PIN_N-1:0] pins_s;
  logic sclk_s, din_s, dem_s, mute_s, band_s;
  logic sclk_d, din_d, dem_d;

  rcfg_sync #(.W(rcfg_pkg::PIN_N)) u_sync (
    .mclk(mclk),
    .rstn(rstn),
    .async_in({band_pick_0, noise_mute_pin, demod_raw, dio_in, sclk_pin}),
    .sync_out(pins_s)
  );

  assign sclk_s = pins_s[rcfg_pkg::PIN_SCLK];
  assign din_s = pins_s[rcfg_pkg::PIN_DIO];
  assign dem_s = pins_s[rcfg_pkg::PIN_DEMOD];
  assign mute_s = pins_s[rcfg_pkg::PIN_MUTE];
  assign band_s = pins_s[rcfg_pkg::PIN_BAND];

  // Edge history
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sclk_d <= 1'b0;
      din_d <= 1'b0;
      dem_d <= 1'b0;
    end else begin
      sclk_d <= sclk_s;
      din_d <= din_s;
      dem_d <= dem_s;
    end
  end

  logic sclk_rise, din_rise;
  assign sclk_rise = sclk_s & ~sclk_d;
  assign din_rise = din_s & ~din_d;

  // ------------------------------------------------------------
  // Serial framing
  // ------------------------------------------------------------
  rcfg_pkg::rcfg_sp_t sp_r;
  logic [19:0] shift_r;
  logic [4:0] nbits_r;
  logic [19:0] word_r;
  logic [31:0] idle_cnt_r;
  logic commit;
  logic timeout;
  logic [19:0] load_mask;

  assign timeout = (idle_cnt_r >= TIMEOUT_CYC) && (sp_r != rcfg_pkg::SP_IDLE)
    && (sp_r != rcfg_pkg::SP_HOLD);
  assign commit = (sp_r == rcfg_pkg::SP_STOP2) && !sclk_s && !timeout;

  // Watchdog on shift clock activity
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      idle_cnt_r <= '0;
    end else if (sclk_s != sclk_d || sp_r == rcfg_pkg::SP_IDLE) begin
      idle_cnt_r <= '0;
    end else if (!timeout) begin
      idle_cnt_r <= idle_cnt_r + 32'h1;
    end
  end

  // Framing state machine
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sp_r <= rcfg_pkg::SP_IDLE;
    end else if (timeout) begin
      sp_r <= rcfg_pkg::SP_HOLD;
    end else begin
      case (sp_r)
        rcfg_pkg::SP_IDLE: begin
          if (sclk_s) sp_r <= rcfg_pkg::SP_REL;
        end
        rcfg_pkg::SP_REL: begin
          if (!sclk_s) begin
            sp_r <= din_s ? rcfg_pkg::SP_IDLE : rcfg_pkg::SP_ARM_LO;
          end
        end
        rcfg_pkg::SP_ARM_LO: begin
          if (sclk_s) begin
            sp_r <= din_s ? rcfg_pkg::SP_HOLD : rcfg_pkg::SP_ARM_HI;
          end
        end
        rcfg_pkg::SP_ARM_HI: begin
          if (!sclk_s) sp_r <= rcfg_pkg::SP_IDLE;
          else if (din_s) sp_r <= rcfg_pkg::SP_ARM_PULSE;
        end
        rcfg_pkg::SP_ARM_PULSE: begin
          if (!sclk_s) sp_r <= rcfg_pkg::SP_IDLE;
          else if (!din_s) sp_r <= rcfg_pkg::SP_SHIFT;
        end
        rcfg_pkg::SP_SHIFT: begin
          if (sclk_s && sclk_d && din_rise) sp_r <= rcfg_pkg::SP_STOP1;
        end
        rcfg_pkg::SP_STOP1: begin
          if (!sclk_s) sp_r <= rcfg_pkg::SP_IDLE;
          else if (!din_s) sp_r <= rcfg_pkg::SP_STOP2;
        end
        rcfg_pkg::SP_STOP2: begin
          if (!sclk_s) sp_r <= rcfg_pkg::SP_IDLE;
        end
        rcfg_pkg::SP_HOLD: begin
          if (!sclk_s) sp_r <= rcfg_pkg::SP_IDLE;
        end
        default: sp_r <= rcfg_pkg::SP_IDLE;
      endcase
    end
  end

  // Bit capture on rising shift clock, MSB first
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      shift_r <= '0;
      nbits_r <= '0;
    end else if (sp_r == rcfg_pkg::SP_ARM_PULSE) begin
      shift_r <= '0;
      nbits_r <= '0;
    end else if (sp_r == rcfg_pkg::SP_SHIFT && sclk_rise) begin
      shift_r <= {shift_r[18:0], din_s};
      if (nbits_r != rcfg_pkg::WORD_W5) nbits_r <= nbits_r + 5'h1;
    end
  end

  // Bits sent cover positions nbits-1 down to 0
  always_comb begin
    if (nbits_r >= rcfg_pkg::WORD_W5) begin
      load_mask = '1;
    end else begin
      load_mask = (20'h1 << nbits_r) - 20'h1;
    end
  end

  // Setting word update at stop
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      word_r <= rcfg_pkg::WORD_RST;
    end else if (commit) begin
      word_r <= (word_r & ~load_mask) | (shift_r & load_mask);
    end
  end

  assign cfg_word = word_r;

  // ------------------------------------------------------------
  // Setting decode
  // ------------------------------------------------------------
  rcfg_pkg::rcfg_word_t w;
  logic [9:0] win_us;
  logic [19:0] win_cyc;
  logic [4:0] need_valid;

  assign w = word_r;

  // Window base from band and code, halved per bandwidth step
  always_comb begin
    if (band_s) begin
      win_us = rcfg_pkg::WIN_433_US[w.check_window];
    end else begin
      win_us = rcfg_pkg::WIN_315_US[w.check_window];
    end
    win_cyc = 20'(win_us * 20'(rcfg_pkg::CYC_PER_US)) >> w.demod_bw;
  end

  // Valid-bit requirement
  always_comb begin
    case (w.valid_count)
      2'h0: need_valid = rcfg_pkg::VBITS_C0;
      2'h1: need_valid = rcfg_pkg::VBITS_C1;
      2'h2: need_valid = rcfg_pkg::VBITS_C2;
      2'h3: need_valid = rcfg_pkg::VBITS_C3;
      default: need_valid = rcfg_pkg::VBITS_C0;
    endcase
  end

  // Mute active only when pin and bit agree
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      mute_enable <= 1'b0;
    end else begin
      mute_enable <= (mute_s == w.mute_control_bit);
    end
  end

  // ------------------------------------------------------------
  // Auto-poll sequencer
  // ------------------------------------------------------------
  rcfg_pkg::rcfg_rx_t rx_r;
  logic [31:0] sleep_cnt_r;
  logic [19:0] run_r;
  logic [4:0] valid_r;
  logic [2:0] bad_r;
  logic dem_edge, bit_ok;

  assign dem_edge = dem_s ^ dem_d;
  assign bit_ok = run_r > win_cyc;

  // Mark and space length counter
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      run_r <= '0;
    end else if (dem_edge || rx_r != rcfg_pkg::RX_POLL) begin
      run_r <= '0;
    end else if (run_r != '1) begin
      run_r <= run_r + 20'h1;
    end
  end

  // Sleep, poll and continuous receive
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rx_r <= rcfg_pkg::RX_AWAKE;
      sleep_cnt_r <= '0;
      valid_r <= '0;
      bad_r <= '0;
    end else if (commit) begin
      rx_r <= (shift_r[15] || !load_mask[15]) && (load_mask[15] ? shift_r[15]
        : w.autopoll_enable_bit) ? rcfg_pkg::RX_SLEEP
        : rcfg_pkg::RX_AWAKE;
      sleep_cnt_r <= '0;
      valid_r <= '0;
      bad_r <= '0;
    end else begin
      case (rx_r)
        rcfg_pkg::RX_AWAKE: rx_r <= rcfg_pkg::RX_AWAKE;
        rcfg_pkg::RX_SLEEP: begin
          if (sleep_cnt_r >= (SLEEP_BASE_CYC << w.sleep_time) - 1) begin
            rx_r <= rcfg_pkg::RX_POLL;
            sleep_cnt_r <= '0;
            valid_r <= '0;
            bad_r <= '0;
          end else begin
            sleep_cnt_r <= sleep_cnt_r + 32'h1;
          end
        end
        rcfg_pkg::RX_POLL: begin
          if (valid_r >= need_valid) begin
            rx_r <= rcfg_pkg::RX_AWAKE;
          end else if (dem_edge && bit_ok) begin
            valid_r <= valid_r + 5'h1;
            bad_r <= '0;
          end else if (dem_edge) begin
            valid_r <= '0;
            if (bad_r == rcfg_pkg::BAD_LIMIT - 3'h1) begin
              rx_r <= rcfg_pkg::RX_SLEEP;
              bad_r <= '0;
            end else begin
              bad_r <= bad_r + 3'h1;
            end
          end
        end
        default: rx_r <= rcfg_pkg::RX_AWAKE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Pin drive
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      dio_oe <= 1'b1;
      dio_out <= 1'b0;
      radio_sleep <= 1'b0;
    end else begin
      dio_oe <= (sp_r == rcfg_pkg::SP_IDLE) && !sclk_s;
      dio_out <= (rx_r == rcfg_pkg::RX_AWAKE) ? dem_s : 1'b0;
      radio_sleep <= (rx_r == rcfg_pkg::RX_SLEEP);
    end
  end

endmodule

// >>> dv/rcfg_port_asserts.sv
`timescale 1ns/1ps
module rcfg_port_asserts #(
  parameter int unsigned TIMEOUT_CYC = 64,
  parameter int unsigned SLEEP_BASE_CYC = 50
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Pins
  input wire logic sclk_pin,
  input wire logic dio_out,
  input wire logic dio_oe,
  input wire logic noise_mute_pin,
  input wire logic demod_raw,
  // Status
  input wire logic radio_sleep,
  input wire logic mute_enable,
  input rcfg_pkg::rcfg_word_t cfg_word
);
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  int unsigned slp_r;
  int unsigned slp_want;
  assign slp_want = SLEEP_BASE_CYC << cfg_word.sleep_time;

  // Cycles spent in the current sleep period
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      slp_r <= 0;
    end else begin
      slp_r <= radio_sleep ? slp_r + 1 : 0;
    end
  end

  sequence s_release;
    dio_oe && $rose(sclk_pin);
  endsequence
  sequence s_commit;
    $changed(cfg_word);
  endsequence

  a_oe_release: assert property (s_release |-> ##[2:4] !dio_oe)
    else $error("data pin not released");
  a_oe_held: assert property (!dio_oe && sclk_pin |=> !dio_oe)
    else $error("data pin driven while clock high");
  a_commit_restore: assert property (s_commit |-> !dio_oe ##1 dio_oe)
    else $error("word changed outside stop");
  a_awake_echo: assert property ((!cfg_word.autopoll_enable_bit && dio_oe)[*5]
    ##0 ($past(demod_raw, 2) == $past(demod_raw, 4))
    |-> dio_out == $past(demod_raw, 3))
    else $error("output does not follow demod data");
  a_sleep_low: assert property (radio_sleep |-> !dio_out)
    else $error("output not low while asleep");
  a_mute_on: assert property ((noise_mute_pin == cfg_word.mute_control_bit)[*4]
    |-> mute_enable)
    else $error("mute not active");
  a_mute_off: assert property ((noise_mute_pin != cfg_word.mute_control_bit)[*4]
    |-> !mute_enable)
    else $error("mute not disabled");
  a_no_poll: assert property ((!cfg_word.autopoll_enable_bit)[*2]
    |-> !radio_sleep)
    else $error("sleep without auto-poll");
  a_sleep_len: assert property ($fell(radio_sleep)
    |-> slp_r + 1 >= slp_want && slp_r <= slp_want + 1)
    else $error("sleep period length wrong");
endmodule

bind rcfg_port rcfg_port_asserts #(.TIMEOUT_CYC(TIMEOUT_CYC),
  .SLEEP_BASE_CYC(SLEEP_BASE_CYC)) i_chk (.mclk(mclk), .rstn(rstn),
  .sclk_pin(sclk_pin), .dio_out(dio_out), .dio_oe(dio_oe),
  .noise_mute_pin(noise_mute_pin), .demod_raw(demod_raw),
  .radio_sleep(radio_sleep), .mute_enable(mute_enable),
  .cfg_word(cfg_word));

// >>> dv/rcfg_host.sv
`timescale 1ns/1ps
module rcfg_host (
  // Clock
  input wire logic mclk,
  // Device side of the data pin
  input wire logic dio_out,
  input wire logic dio_oe,
  // Host drive
  output logic sclk_pin,
  output logic dio_in
);
  // ----------------------------------------------------------------
  // Host link driver
  // ----------------------------------------------------------------
  logic drv = 1'b0;
  logic host_en = 1'b0;

  // Pin level: device, host, or floating as inverse of last
  assign dio_in = dio_oe ? dio_out : (host_en ? drv : ~drv);
  initial sclk_pin = 1'b0;

  // One link level, held for half of a 320 ns period
  task automatic lvl(input logic s, input logic d);
    @(posedge mclk);
    sclk_pin <= s;
    drv <= d;
    repeat (3) @(posedge mclk);
  endtask

  // Start, n bits MSB first, then stop or a stall
  task automatic frame(input logic [19:0] w, input int n, input int stall);
    host_en <= 1'b1;
    lvl(1'b1, 1'b0);
    lvl(1'b0, 1'b0);
    lvl(1'b1, 1'b0);
    lvl(1'b1, 1'b1);
    lvl(1'b1, 1'b0);
    for (int i = n - 1; i >= 0; i--) begin
      lvl(1'b0, w[i]);
      lvl(1'b1, w[i]);
    end
    if (stall > 0) begin
      lvl(1'b0, 1'b0);
      repeat (stall) @(posedge mclk);
    end else begin
      lvl(1'b1, 1'b0);
      lvl(1'b1, 1'b1);
      lvl(1'b1, 1'b0);
      lvl(1'b0, 1'b0);
    end
    host_en <= 1'b0;
  endtask
endmodule

// >>> dv/tb.sv
`timescale 1ns/1ps
module tb;
  // ----------------------------------------------------------------
  // Bench
  // ----------------------------------------------------------------
  localparam int unsigned TO_CYC = 64;
  localparam int unsigned SB_CYC = 50;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic noise_mute_pin = 1'b1;
  logic band_pick_0 = 1'b1;
  logic demod_raw = 1'b0;
  logic sclk_pin, dio_in, dio_out, dio_oe, radio_sleep, mute_enable;
  rcfg_pkg::rcfg_word_t cfg_word;
  rcfg_pkg::rcfg_word_t exp_w;
  int miscompares = 0;
  int num_checks = 0;
  logic [15:0] rnd = 16'hfe8f;
  logic [11:0] cyc = 12'h000;
  logic [1:0] dmode = 2'h0;
  int ns[6] = '{20, 3, 20, 18, 1, 20};

`define CHK(a, b, m) begin num_checks++; if ((a) !== (b)) begin \
  miscompares++; $display("CHECK FAILED t=%0t %s", $time, m); end end

  always #20 mclk = ~mclk;

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Legal word: fixed bits and bit 0 kept clear
  function automatic logic [19:0] mk_word(input logic [15:0] r);
    return {2'b01, r[0], 2'b00, r[15:4], r[3:2], 1'b0};
  endfunction
  // Last n bits replace the low end of the word
  function automatic logic [19:0] merge(input logic [19:0] o, w, input int n);
    logic [19:0] m;
    m = (20'h1 << n) - 20'h1;
    return (o & ~m) | (w & m);
  endfunction

  rcfg_port #(.TIMEOUT_CYC(TO_CYC), .SLEEP_BASE_CYC(SB_CYC)) i_dut (
    .mclk(mclk), .rstn(rstn), .sclk_pin(sclk_pin), .dio_in(dio_in),
    .dio_out(dio_out), .dio_oe(dio_oe), .noise_mute_pin(noise_mute_pin),
    .band_pick_0(band_pick_0), .demod_raw(demod_raw),
    .radio_sleep(radio_sleep), .mute_enable(mute_enable),
    .cfg_word(cfg_word));
  rcfg_host i_host (.mclk(mclk), .dio_out(dio_out), .dio_oe(dio_oe),
    .sclk_pin(sclk_pin), .dio_in(dio_in));

  // Demod data: random, short runs or long runs
  always @(posedge mclk) begin
    cyc <= cyc + 12'h001;
    rnd <= lfsr(rnd);
    demod_raw <= dmode == 2'h1 ? cyc[3] : (dmode == 2'h2 ? cyc[10] : rnd[0]);
  end

  task automatic wait_lvl(input int s, input logic v, input int lim);
    for (int k = 0; k < lim; k++) begin
      if ((s == 0 ? dio_oe : (s == 1 ? radio_sleep : dio_out)) === v) break;
      @(posedge mclk);
    end
  endtask

  task automatic send(input logic [19:0] w, input int n, input int stall);
    i_host.frame(w, n, stall);
    wait_lvl(0, 1'b1, 200);
    repeat (2) @(posedge mclk);
  endtask

  task test_done;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Watchdog
  initial begin
    #(40 * 40000);
    miscompares++;
    test_done();
  end

  initial begin
    repeat (5) @(posedge mclk);
    rstn <= 1'b1;
    repeat (2) @(posedge mclk);
    exp_w = rcfg_pkg::WORD_RST;
    `CHK(cfg_word, exp_w, "reset word")
    `CHK(dio_oe, 1'b1, "reset drive")
    for (int i = 0; i < 6; i++) begin
      logic [19:0] w;
      w = mk_word(rnd);
      exp_w = merge(exp_w, w, ns[i]);
      send(w, ns[i], 0);
      `CHK(cfg_word, exp_w, "loaded word")
      repeat (4) @(posedge mclk);
      `CHK(mute_enable, noise_mute_pin == exp_w[17], "mute")
    end
    $display("test loads done");
    send(mk_word(rnd), 5, TO_CYC + 16);
    `CHK(cfg_word, exp_w, "stalled frame kept word")
    $display("test stall done");
    dmode <= 2'h1;
    exp_w = {5'h09, 3'h0, 3'h7, 2'h1, 2'h3, 2'h3, 3'h0};
    send(exp_w, 20, 0);
    `CHK(radio_sleep, 1'b1, "sleep after enable")
    `CHK(dio_out, 1'b0, "output low asleep")
    wait_lvl(1, 1'b0, 200);
    wait_lvl(1, 1'b1, 400);
    `CHK(radio_sleep, 1'b1, "short runs sleep")
    band_pick_0 <= 1'b0;
    dmode <= 2'h2;
    repeat (3000) @(posedge mclk);
    `CHK(dio_out, 1'b0, "long runs too short at low band")
    band_pick_0 <= 1'b1;
    wait_lvl(2, 1'b1, 9000);
    `CHK(dio_out, 1'b1, "woke on long runs")
    dmode <= 2'h1;
    repeat (1500) @(posedge mclk);
    `CHK(radio_sleep, 1'b0, "stays awake")
    exp_w.valid_count = 2'h0;
    send(exp_w, 20, 0);
    wait_lvl(1, 1'b0, 200);
    repeat (200) @(posedge mclk);
    `CHK(radio_sleep, 1'b0, "no valid bits needed")
    dmode <= 2'h0;
    exp_w.autopoll_enable_bit = 1'b0;
    send(exp_w, 20, 0);
    `CHK(cfg_word, exp_w, "poll off word")
    $display("test poll done");
    test_done();
  end
endmodule
